// [hw/ctrl_port_pkg.sv]
// constants, carrier types and the state type of the dual serial control port
// assumes: a register file on sys_clk_in answers a read within the same cycle
package ctrl_port_pkg;
  localparam logic [5:0] TW_DEV_ADDR = 6'h14;
  localparam logic [6:0] TWI_DEV_ADDR = 7'h18;
  localparam logic [1:0] TT_WRITE = 2'h1;
  localparam logic [1:0] TT_READ = 2'h3;
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_MIN_PERIOD_NS = 1000000 / SCL_MAX_KHZ;
  localparam int SCL_MIN_PERIOD_CYC = SCL_MIN_PERIOD_NS / SYS_CLK_PERIOD_NS;
  localparam logic [4:0] TW_READ_BITS = 5'h18;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] rdata;
  } reg_rsp_t;

  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK, I_TXLOAD} twi_state_t;
endpackage

// [hw/dual_serial_control_port.sv]
// dual serial control port: three-wire slave on the link clock, two-wire slave on sys_clk_in
// assumes: register file on sys_clk_in, combinational read of reg_req_out.addr;
// bench resolves the data wire from ctrl_data_out and ctrl_data_oe_n_out
`timescale 1ns/1ps
`default_nettype none
module dual_serial_control_port (
  // system
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // pins
  input wire logic port_select_pin_in,
  input wire logic ctrl_clock_pin_in,
  input wire logic ctrl_data_pin_in,
  input wire logic ctrl_mode_pin_in,
  output logic ctrl_data_out,
  output logic ctrl_data_oe_n_out,
  output logic quick_mute_out,
  // register file
  output ctrl_port_pkg::reg_req_t reg_req_out,
  input wire ctrl_port_pkg::reg_rsp_t reg_rsp_in
);
  import ctrl_port_pkg::*;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic mode_s1;
    logic mode_s2;
    logic req_s1;
    logic req_s2;
    logic req_q;
    twi_state_t ist;
    logic [3:0] bitcnt;
    logic [1:0] byte_idx;
    logic rw;
    logic [7:0] shreg;
    logic [7:0] hold;
    logic half;
    logic inc_pend;
    logic pull;
    logic [7:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic rd_busy;
    logic [16:0] rd_word;
    logic ack_tgl;
    logic mute_q;
  } sys_state_t;

  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic ack_s1;
    logic ack_s2;
    logic mode_q;
    logic [4:0] bitcnt;
    logic [7:0] shreg;
    logic selected;
    logic [1:0] ttype;
    logic [1:0] byte_idx;
    logic [7:0] hi;
    logic req_tgl;
    logic req_rd;
    logic [6:0] req_addr;
    logic [15:0] req_data;
    logic [23:0] tx;
    logic tx_active;
  } tw_state_t;

  typedef struct packed {
    logic bit_val;
    logic en;
  } tw_drive_t;

  sys_state_t sys_ff;
  sys_state_t nxt_sys;
  tw_state_t tw_ff;
  tw_state_t nxt_tw;
  tw_drive_t drv_ff;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [4:0] tw_cnt;
  logic [7:0] tw_byte;
  logic rd_ok;

  // two-wire side and register access on sys_clk_in
  assign scl_rise = sys_ff.scl_s2 & ~sys_ff.scl_q;
  assign scl_fall = ~sys_ff.scl_s2 & sys_ff.scl_q;
  assign start_det = sys_ff.scl_s2 & sys_ff.scl_q & sys_ff.sda_q & ~sys_ff.sda_s2;
  assign stop_det = sys_ff.scl_s2 & sys_ff.scl_q & ~sys_ff.sda_q & sys_ff.sda_s2;

  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.sel_s1 = port_select_pin_in;
    nxt_sys.sel_s2 = sys_ff.sel_s1;
    nxt_sys.scl_s1 = ctrl_clock_pin_in;
    nxt_sys.scl_s2 = sys_ff.scl_s1;
    nxt_sys.scl_q = sys_ff.scl_s2;
    nxt_sys.sda_s1 = ctrl_data_pin_in;
    nxt_sys.sda_s2 = sys_ff.sda_s1;
    nxt_sys.sda_q = sys_ff.sda_s2;
    nxt_sys.mode_s1 = ctrl_mode_pin_in;
    nxt_sys.mode_s2 = sys_ff.mode_s1;
    nxt_sys.req_s1 = tw_ff.req_tgl;
    nxt_sys.req_s2 = sys_ff.req_s1;
    nxt_sys.req_q = sys_ff.req_s2;
    nxt_sys.wr = 1'b0;
    nxt_sys.mute_q = sys_ff.sel_s2 & sys_ff.mode_s2;
    // three-wire requests; fields stay still from the toggle until the answer toggles back
    if (sys_ff.rd_busy) begin
      nxt_sys.rd_word = {reg_rsp_in.valid, reg_rsp_in.rdata};
      nxt_sys.rd_busy = 1'b0;
      nxt_sys.ack_tgl = sys_ff.req_q;
    end else if (sys_ff.req_s2 != sys_ff.req_q && !sys_ff.sel_s2) begin
      nxt_sys.addr = {1'b0, tw_ff.req_addr};
      if (tw_ff.req_rd) begin
        nxt_sys.rd_busy = 1'b1;
      end else begin
        nxt_sys.wr = 1'b1;
        nxt_sys.wdata = tw_ff.req_data;
        nxt_sys.ack_tgl = sys_ff.req_s2;
      end
    end
    if (!sys_ff.sel_s2) begin
      nxt_sys.ist = I_IDLE;
      nxt_sys.pull = 1'b0;
    end else if (start_det) begin
      nxt_sys.ist = I_RX;
      nxt_sys.bitcnt = 4'h0;
      nxt_sys.byte_idx = 2'h0;
      nxt_sys.pull = 1'b0;
    end else if (stop_det) begin
      nxt_sys.ist = I_IDLE;
      nxt_sys.pull = 1'b0;
    end else begin
      unique case (sys_ff.ist)
        I_IDLE: begin
          nxt_sys.pull = 1'b0;
        end
        I_RX: begin
          if (scl_rise) begin
            nxt_sys.shreg = {sys_ff.shreg[6:0], sys_ff.sda_s2};
            nxt_sys.bitcnt = sys_ff.bitcnt + 4'h1;
          end else if (scl_fall && sys_ff.bitcnt == BYTE_BITS) begin
            nxt_sys.bitcnt = 4'h0;
            nxt_sys.pull = 1'b1;
            nxt_sys.ist = I_ACK;
            unique case (sys_ff.byte_idx)
              2'h0: begin
                if (sys_ff.shreg[7:1] == TWI_DEV_ADDR) begin
                  nxt_sys.rw = sys_ff.shreg[0];
                  nxt_sys.byte_idx = 2'h1;
                end else begin
                  nxt_sys.pull = 1'b0;
                  nxt_sys.ist = I_IDLE;
                end
              end
              2'h1: begin
                nxt_sys.addr = sys_ff.shreg;
                nxt_sys.byte_idx = 2'h2;
              end
              2'h2: begin
                nxt_sys.hold = sys_ff.shreg;
                nxt_sys.byte_idx = 2'h3;
              end
              2'h3: begin
                nxt_sys.wr = 1'b1;
                nxt_sys.wdata = {sys_ff.hold, sys_ff.shreg};
                nxt_sys.inc_pend = 1'b1;
                nxt_sys.byte_idx = 2'h2;
              end
            endcase
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            nxt_sys.pull = 1'b0;
            nxt_sys.inc_pend = 1'b0;
            if (sys_ff.inc_pend) begin
              nxt_sys.addr = sys_ff.addr + 8'h01;
            end
            if (sys_ff.rw) begin
              nxt_sys.ist = I_TX;
              nxt_sys.half = 1'b0;
              nxt_sys.shreg = reg_rsp_in.rdata[15:8];
              nxt_sys.pull = ~reg_rsp_in.rdata[15];
            end else begin
              nxt_sys.ist = I_RX;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            nxt_sys.bitcnt = sys_ff.bitcnt + 4'h1;
            nxt_sys.shreg = {sys_ff.shreg[6:0], 1'b0};
            nxt_sys.pull = ~sys_ff.shreg[6];
            if (sys_ff.bitcnt == BYTE_BITS - 4'h1) begin
              nxt_sys.pull = 1'b0;
              nxt_sys.ist = I_TXACK;
            end
          end
        end
        I_TXACK: begin
          if (scl_rise) begin
            if (sys_ff.sda_s2) begin
              nxt_sys.ist = I_IDLE;
            end else begin
              nxt_sys.ist = I_TXLOAD;
              nxt_sys.half = ~sys_ff.half;
              if (sys_ff.half) begin
                nxt_sys.addr = sys_ff.addr + 8'h01;
              end
            end
          end
        end
        I_TXLOAD: begin
          if (scl_fall) begin
            nxt_sys.bitcnt = 4'h0;
            nxt_sys.ist = I_TX;
            nxt_sys.shreg = sys_ff.half ? reg_rsp_in.rdata[7:0] : reg_rsp_in.rdata[15:8];
            nxt_sys.pull = sys_ff.half ? ~reg_rsp_in.rdata[7] : ~reg_rsp_in.rdata[15];
          end
        end
        default: begin
          nxt_sys.ist = I_IDLE;
          nxt_sys.pull = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  // three-wire side on the link clock
  assign tw_cnt = (ctrl_mode_pin_in != tw_ff.mode_q) ? 5'h00 : tw_ff.bitcnt;
  assign tw_byte = {ctrl_data_pin_in, tw_ff.shreg[7:1]};
  assign rd_ok = (tw_ff.ack_s2 == tw_ff.req_tgl) & sys_ff.rd_word[16];

  always_comb begin
    nxt_tw = tw_ff;
    nxt_tw.sel_s1 = port_select_pin_in;
    nxt_tw.sel_s2 = tw_ff.sel_s1;
    nxt_tw.ack_s1 = sys_ff.ack_tgl;
    nxt_tw.ack_s2 = tw_ff.ack_s1;
    nxt_tw.mode_q = ctrl_mode_pin_in;
    nxt_tw.shreg = tw_byte;
    nxt_tw.bitcnt = tw_cnt + 5'h01;
    if (tw_ff.sel_s2) begin
      nxt_tw.selected = 1'b0;
      nxt_tw.tx_active = 1'b0;
    end else if (!ctrl_mode_pin_in) begin
      nxt_tw.tx_active = 1'b0;
      if (tw_cnt[2:0] == 3'h7) begin
        nxt_tw.selected = (tw_byte[7:2] == TW_DEV_ADDR);
        nxt_tw.ttype = tw_byte[1:0];
        nxt_tw.byte_idx = 2'h0;
        if (tw_byte[7:2] == TW_DEV_ADDR && tw_byte[1:0] == TT_READ) begin
          nxt_tw.tx = {sys_ff.rd_word[7:0], sys_ff.rd_word[15:8],
                       tw_ff.req_addr, ~rd_ok};
          nxt_tw.tx_active = 1'b1;
        end
      end
    end else begin
      if (tw_ff.tx_active) begin
        nxt_tw.tx = {1'b0, tw_ff.tx[23:1]};
        if (tw_cnt == TW_READ_BITS - 5'h01) begin
          nxt_tw.tx_active = 1'b0;
        end
      end
      if (tw_ff.selected && tw_ff.ttype == TT_WRITE && tw_cnt[2:0] == 3'h7) begin
        unique case (tw_ff.byte_idx)
          2'h0: begin
            nxt_tw.req_addr = tw_byte[7:1];
            if (tw_byte[0]) begin
              nxt_tw.req_rd = 1'b1;
              nxt_tw.req_tgl = ~tw_ff.req_tgl;
              nxt_tw.selected = 1'b0;
            end else begin
              nxt_tw.byte_idx = 2'h1;
            end
          end
          2'h1: begin
            nxt_tw.hi = tw_byte;
            nxt_tw.byte_idx = 2'h2;
          end
          2'h2: begin
            nxt_tw.req_data = {tw_ff.hi, tw_byte};
            nxt_tw.req_rd = 1'b0;
            nxt_tw.req_tgl = ~tw_ff.req_tgl;
            nxt_tw.selected = 1'b0;
          end
          2'h3: begin
            nxt_tw.selected = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ctrl_clock_pin_in or posedge rst_in) begin
    if (rst_in) begin
      tw_ff <= '0;
    end else begin
      tw_ff <= nxt_tw;
    end
  end

  // read data changes on the falling edge so it is settled for the next rising edge
  always_ff @(negedge ctrl_clock_pin_in or posedge rst_in) begin
    if (rst_in) begin
      drv_ff <= '0;
    end else begin
      drv_ff.bit_val <= tw_ff.tx[0];
      drv_ff.en <= tw_ff.tx_active;
    end
  end

  // outputs
  assign ctrl_data_out = sys_ff.sel_s2 ? 1'b0 : drv_ff.bit_val;
  assign ctrl_data_oe_n_out = sys_ff.sel_s2 ? ~sys_ff.pull : ~drv_ff.en;
  assign quick_mute_out = sys_ff.mute_q;
  assign reg_req_out = '{wr: sys_ff.wr, addr: sys_ff.addr, wdata: sys_ff.wdata};

  // checks
  a_mute_follow: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (port_select_pin_in && ctrl_mode_pin_in) [*4] |-> quick_mute_out)
    else $error("quick mute does not follow the mode pin");

  a_addr_ack: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && sys_ff.ist == I_RX && scl_fall && sys_ff.bitcnt == BYTE_BITS
    && sys_ff.byte_idx == 2'h0 && !start_det && !stop_det
    |=> (ctrl_data_oe_n_out == ($past(sys_ff.shreg[7:1]) != TWI_DEV_ADDR)))
    else $error("address acknowledge does not match the slave address");

  a_ack_held: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && sys_ff.ist == I_ACK && sys_ff.scl_s2 |-> !ctrl_data_oe_n_out)
    else $error("acknowledge released while the clock is high");

  a_sda_stable_high: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && sys_ff.scl_s2 && sys_ff.scl_q && $past(sys_ff.scl_s2)
    |-> $stable(sys_ff.pull))
    else $error("data drive changed while the clock is high");

  a_pair_incr: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && sys_ff.ist == I_ACK && sys_ff.inc_pend && scl_fall
    && !start_det && !stop_det |=> sys_ff.addr == $past(sys_ff.addr) + 8'h01)
    else $error("register address not incremented after a pair");

  a_start_rx: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && start_det |=> sys_ff.ist == I_RX && sys_ff.bitcnt == 4'h0 ##0 !sys_ff.pull)
    else $error("start condition not taken");

  a_nack_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && sys_ff.ist == I_TXACK && scl_rise && sys_ff.sda_s2 && !start_det
    |=> ctrl_data_oe_n_out [*3])
    else $error("data line not released after a negative acknowledge");

  a_tw_write_lands: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !sys_ff.sel_s2 && !sys_ff.rd_busy && sys_ff.req_s2 != sys_ff.req_q && !tw_ff.req_rd
    |=> reg_req_out.wr && reg_req_out.wdata == tw_ff.req_data ##1 !reg_req_out.wr)
    else $error("three-wire write did not land as one word");

  a_tw_drive_read: assert property (@(posedge ctrl_clock_pin_in) disable iff (rst_in)
    tw_ff.tx_active |-> tw_ff.ttype == TT_READ && !tw_ff.sel_s2)
    else $error("three-wire data driven outside a read");

  a_tw_select_off: assert property (@(posedge ctrl_clock_pin_in) disable iff (rst_in)
    tw_ff.sel_s2 |=> !tw_ff.tx_active && !tw_ff.selected)
    else $error("three-wire logic active in two-wire mode");

  c_twi_write: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.sel_s2 && reg_req_out.wr);
  c_twi_read: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    sys_ff.ist == I_TXLOAD ##1 sys_ff.ist == I_TX);
  c_tw_write: cover property (@(posedge sys_clk_in) disable iff (rst_in)
    !sys_ff.sel_s2 && reg_req_out.wr);
  c_tw_read: cover property (@(posedge ctrl_clock_pin_in) disable iff (rst_in)
    $fell(tw_ff.tx_active) && tw_ff.mode_q);
endmodule
`default_nettype wire

// [bench/host_master.sv]
// host-side bus master for both serial protocols of the control port
// assumes: the bench resolves the data wire and feeds it back on wire_in
`timescale 1ns/1ps
`default_nettype none
module host_master (
  // pins toward the device
  output var logic clk_out,
  output var logic data_out,
  output var logic mode_out,
  // resolved data wire
  input wire logic wire_in
);
  localparam int TW_HALF = 16;
  localparam int I2C_Q = 650;
  // idle: clock parked high, data released to the pull-up level
  initial begin
    clk_out = 1'b1;
    data_out = 1'b1;
    mode_out = 1'b0;
  end
  // two-wire mode: the mode pin acts as the quick mute input
  task automatic set_mode(input logic m);
    mode_out = m;
  endtask
  // one three-wire byte; rx samples the wire just before each rising edge
  task automatic tw_byte(input logic mode, input logic [7:0] b, output logic [7:0] rx);
    mode_out = mode;
    for (int i = 0; i < 8; i++) begin
      clk_out = 1'b0;
      data_out = b[i];
      #TW_HALF;
      rx[i] = wire_in;
      clk_out = 1'b1;
      #TW_HALF;
    end
    data_out = 1'b1;
  endtask
  // start, or repeated start when entered with the clock low
  task automatic i2c_start();
    data_out = 1'b1;
    #I2C_Q clk_out = 1'b1;
    #I2C_Q data_out = 1'b0;
    #I2C_Q clk_out = 1'b0;
  endtask
  task automatic i2c_stop();
    data_out = 1'b0;
    #I2C_Q clk_out = 1'b1;
    #I2C_Q data_out = 1'b1;
    #I2C_Q;
  endtask
  // eight bits msb first and the acknowledge slot; data moves only while clock low
  task automatic i2c_bits(input logic [8:0] b, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #I2C_Q data_out = b[i];
      #I2C_Q clk_out = 1'b1;
      #I2C_Q rx[i] = wire_in;
      #I2C_Q clk_out = 1'b0;
    end
    data_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench of the dual serial control port
// assumes: host_master drives the bus pins, the bench models the register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp); \
    end \
  end
module tb;
  import ctrl_port_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sel = 1'b0;
  logic hclk, hdata, hmode, wire_lvl, dout, oe_n, mute;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [15:0] regs [256];
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] rx;
  logic [8:0] r9;
  logic [7:0] wd [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
  always #5 sys_clk_in = ~sys_clk_in;
  // wire with pull-up: the device wins wherever it drives
  assign wire_lvl = oe_n ? hdata : (sel ? (hdata & dout) : dout);
  assign rsp.valid = (req.addr < 8'h40);
  assign rsp.rdata = regs[req.addr];
  always @(posedge sys_clk_in) if (req.wr) regs[req.addr] <= req.wdata;
  host_master host (.clk_out(hclk), .data_out(hdata), .mode_out(hmode), .wire_in(wire_lvl));
  dual_serial_control_port uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .port_select_pin_in(sel),
    .ctrl_clock_pin_in(hclk), .ctrl_data_pin_in(wire_lvl), .ctrl_mode_pin_in(hmode),
    .ctrl_data_out(dout), .ctrl_data_oe_n_out(oe_n), .quick_mute_out(mute),
    .reg_req_out(req), .reg_rsp_in(rsp));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tw_write(input logic [7:0] dev, input logic [6:0] ra, input logic [15:0] d);
    host.tw_byte(1'b0, dev, rx);
    host.tw_byte(1'b1, {ra, 1'b0}, rx);
    host.tw_byte(1'b1, d[15:8], rx);
    host.tw_byte(1'b1, d[7:0], rx);
    #2000;
  endtask
  // prepare read, read address byte, then three returned bytes
  task automatic tw_read(input logic [6:0] ra, input logic [23:0] exp, input string msg);
    logic [23:0] got;
    host.tw_byte(1'b0, {TW_DEV_ADDR, TT_WRITE}, rx);
    host.tw_byte(1'b1, {ra, 1'b1}, rx);
    #2000;
    host.tw_byte(1'b0, {TW_DEV_ADDR, TT_READ}, rx);
    for (int i = 2; i >= 0; i--) begin
      host.tw_byte(1'b1, 8'hFF, rx);
      got[i*8 +: 8] = rx;
    end
    `CHK(got, exp, msg)
    #2000;
  endtask
  task automatic i2c_wr(input logic [7:0] b, input logic exp_ack, input string msg);
    host.i2c_bits({b, 1'b1}, r9);
    `CHK(~r9[0], exp_ack, msg)
  endtask
  task automatic i2c_read(input logic [7:0] ra, input logic [31:0] exp);
    host.i2c_start();
    i2c_wr({TWI_DEV_ADDR, 1'b0}, 1'b1, "ack address");
    i2c_wr(ra, 1'b1, "ack register");
    host.i2c_start();
    i2c_wr({TWI_DEV_ADDR, 1'b1}, 1'b1, "ack read address");
    for (int i = 3; i >= 0; i--) begin
      host.i2c_bits({8'hFF, i == 0}, r9);
      `CHK(r9[8:1], exp[i*8 +: 8], "read byte")
    end
    #100;
    `CHK(oe_n, 1'b1, "line released")
    host.i2c_stop();
  endtask
  initial begin
    foreach (regs[i]) regs[i] = 16'h0000;
    repeat (8) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    tw_write({TW_DEV_ADDR, TT_WRITE}, 7'h11, 16'hA55A);
    `CHK(regs[8'h11], 16'hA55A, "three-wire write")
    tw_write({6'h15, TT_WRITE}, 7'h11, 16'h0F0F);
    `CHK(regs[8'h11], 16'hA55A, "foreign device")
    tw_read(7'h11, 24'h22A55A, "three-wire read");
    tw_read(7'h7F, 24'hFF0000, "invalid register");
    `CHK(mute, 1'b0, "mute while three-wire")
    $display("three-wire tests done");
    @(negedge sys_clk_in) sel = 1'b1;
    repeat (10) @(negedge sys_clk_in);
    host.set_mode(1'b1);
    repeat (6) @(negedge sys_clk_in);
    `CHK(mute, 1'b1, "mute on")
    host.set_mode(1'b0);
    repeat (6) @(negedge sys_clk_in);
    `CHK(mute, 1'b0, "mute off")
    host.i2c_start();
    i2c_wr({TWI_DEV_ADDR, 1'b0}, 1'b1, "ack address");
    i2c_wr(8'h20, 1'b1, "ack register");
    for (int i = 0; i < 4; i++) begin
      i2c_wr(wd[i], 1'b1, "ack data");
    end
    host.i2c_stop();
    `CHK(regs[8'h20], 16'h1234, "first pair")
    `CHK(regs[8'h21], 16'h5678, "second pair")
    host.i2c_start();
    i2c_wr({7'h19, 1'b0}, 1'b0, "no ack foreign");
    host.i2c_stop();
    i2c_read(8'h20, 32'h12345678);
    i2c_read(8'h11, 32'hA55A0000);
    $display("two-wire tests done");
    complete_run();
  end
  initial begin
    #900000;
    num_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    complete_run();
  end
endmodule
`default_nettype wire
